// >>> pkg/lcm_defs.svh
// constants for the ladder counter, modes 2 to 6
// assumes one scan clock and apb register access
//
// Function
// - mode 2: up stops at 999999, down stops at 0
// - mode 2: init at power-up and run/stop
// - mode 2 init: 0 counting up, else preset
// - mode 3: up stops at preset, down at 0
// - mode 3: run power loss value restored
// - mode 3: keep flag holds across run/stop
// - mode 4: up passes preset, down halts 0
// - mode 4: retains on run power loss, keep flag
// - mode 5: coil on at nonzero preset reached
// - mode 5: counts past preset, power loss clears
// - mode 5: reset input holds value at 0
// - mode 5: run/stop change forces 0
// - mode 6: coil on at nonzero preset reached
// - mode 6: reset clears to zero except during power loss, power-up or run/stop change
// - mode 6: run power loss value restored
// - mode 6: keep flag holds across run/stop
// - direction low counts up, high down
// - reset input clears, release resumes counting
// - current and preset span 0 to 999999
`ifndef LCM_DEFS_SVH
`define LCM_DEFS_SVH
// =====================================================
// register map
`define LCM_ADDR_CTRL 8'h00
`define LCM_ADDR_PRESET 8'h04
`define LCM_ADDR_CURRENT 8'h08
`define LCM_ADDR_STATUS 8'h0C
// =====================================================
// fields and values
`define LCM_MAX_COUNT 20'hF423F
`define LCM_MODE_2 3'h2
`define LCM_MODE_3 3'h3
`define LCM_MODE_4 3'h4
`define LCM_MODE_5 3'h5
`define LCM_MODE_6 3'h6
`define LCM_RST_MODE 3'h2
`define LCM_RST_PRESET 20'h00000
`define LCM_ZERO 20'h00000
`define LCM_ONE 20'h00001
// control word fields: keep flag bit, top bit of the mode field
`define LCM_KEEP_BIT 3
`define LCM_MODE_MSB 2
`endif

// >>> pkg/lcm_pkg.sv
// types shared by the ladder counter
// assumes lcm_defs.svh supplies the numbers
package lcm_pkg;
    // =====================================================
    // rung inputs from the ladder program, sampled each scan
    typedef struct packed
    {
        logic pulse; // count pulse
        logic dir; // high counts down
        logic clr; // reset input
    } lcm_rung_t;
    // software control bits
    typedef struct packed
    {
        logic keep; // keep value across run/stop
        logic [2:0] mode; // counting mode 2..6
    } lcm_ctrl_t;
endpackage

// >>> logic/lcm_counter.sv
// general purpose ladder counter, modes 2 to 6, apb slave
// assumes rung inputs, run state and power flag sync to clk
`timescale 1ns/1ps
`include "lcm_defs.svh"
module lcm_counter #(
    parameter int CNT_W = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire lcm_pkg::lcm_rung_t rung,
    input wire logic run_mode,
    input wire logic power_lost,
    output logic counter_status_coil,
    output logic [CNT_W-1:0] count_value
);
    import lcm_pkg::*;

    // =====================================================
    // state
    lcm_ctrl_t ctrl_q; // mode and keep flag
    logic [CNT_W-1:0] preset_q; // preset value
    logic [CNT_W-1:0] cur_q; // current value
    logic [CNT_W-1:0] cur_d;
    logic [CNT_W-1:0] saved_q; // value kept through power loss
    logic saved_vld_q; // saved value is valid
    logic pulse_prev_q; // last pulse level
    logic run_prev_q; // last run level
    logic pwr_prev_q; // last power-lost level
    logic coil_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    // =====================================================
    // event decode
    logic pulse_rise; // rising edge of count pulse
    logic run_chg; // run/stop transition
    logic pwr_fall; // power going away
    logic pwr_up; // power coming back
    logic retentive; // mode keeps value on power loss
    logic apb_wr; // write completes this edge
    logic addr_ok; // address is mapped

    assign pulse_rise = rung.pulse & ~pulse_prev_q;
    assign run_chg = run_mode ^ run_prev_q;
    assign pwr_fall = power_lost & ~pwr_prev_q;
    assign pwr_up = ~power_lost & pwr_prev_q;
    assign retentive = (ctrl_q.mode == `LCM_MODE_3) || (ctrl_q.mode == `LCM_MODE_4)
        || (ctrl_q.mode == `LCM_MODE_6);
    assign apb_wr = psel & penable & pwrite & pready_q;
    assign addr_ok = (paddr == `LCM_ADDR_CTRL) || (paddr == `LCM_ADDR_PRESET)
        || (paddr == `LCM_ADDR_CURRENT) || (paddr == `LCM_ADDR_STATUS);

    // =====================================================
    // functions
    // value loaded at power-up or run/stop change
    function automatic logic [CNT_W-1:0] init_val(
        input logic [2:0] mode,
        input logic down,
        input logic [CNT_W-1:0] pre
    );
        logic [CNT_W-1:0] v;
        v = CNT_W'(`LCM_ZERO);
        if (mode != `LCM_MODE_5 && mode != `LCM_MODE_6 && down)
        begin
            v = pre;
        end
        return v;
    endfunction

    // coil decision from a value
    function automatic logic coil_of(
        input logic [2:0] mode,
        input logic [CNT_W-1:0] v,
        input logic [CNT_W-1:0] pre
    );
        logic c;
        c = (v >= pre);
        if (mode == `LCM_MODE_5 || mode == `LCM_MODE_6)
        begin
            c = c && (pre != CNT_W'(`LCM_ZERO));
        end
        return c;
    endfunction

    // =====================================================
    // next current value, highest priority first
    always_comb
    begin
        cur_d = cur_q;
        if (power_lost)
        begin
            if (pwr_fall && ctrl_q.mode == `LCM_MODE_5)
            begin
                cur_d = CNT_W'(`LCM_ZERO);
            end
        end
        else if (pwr_up)
        begin
            if (retentive && saved_vld_q)
            begin
                cur_d = saved_q;
            end
            else
            begin
                cur_d = init_val(ctrl_q.mode, rung.dir, preset_q);
            end
        end
        else if (run_chg)
        begin
            if (retentive && ctrl_q.keep)
            begin
                cur_d = cur_q;
            end
            else
            begin
                cur_d = init_val(ctrl_q.mode, rung.dir, preset_q);
            end
        end
        else if (rung.clr)
        begin
            cur_d = CNT_W'(`LCM_ZERO);
        end
        else if (pulse_rise)
        begin
            if (!rung.dir)
            begin
                if (ctrl_q.mode == `LCM_MODE_3 && cur_q >= preset_q)
                begin
                    cur_d = cur_q;
                end
                else if (cur_q < CNT_W'(`LCM_MAX_COUNT))
                begin
                    cur_d = cur_q + CNT_W'(`LCM_ONE);
                end
            end
            else if (cur_q != CNT_W'(`LCM_ZERO))
            begin
                cur_d = cur_q - CNT_W'(`LCM_ONE);
            end
        end
    end

    // =====================================================
    // current value and coil registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cur_q <= CNT_W'(`LCM_ZERO);
            coil_q <= 1'b0;
        end
        else
        begin
            cur_q <= cur_d;
            coil_q <= coil_of(ctrl_q.mode, cur_d, preset_q);
        end
    end

    // =====================================================
    // edge history of pulse, run and power
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pulse_prev_q <= 1'b0;
            run_prev_q <= 1'b0;
            pwr_prev_q <= 1'b0;
        end
        else
        begin
            pulse_prev_q <= rung.pulse;
            run_prev_q <= run_mode;
            pwr_prev_q <= power_lost;
        end
    end

    // =====================================================
    // retained copy: taken at every power fall, valid only in run and a retentive mode
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            saved_q <= CNT_W'(`LCM_ZERO);
            saved_vld_q <= 1'b0;
        end
        else if (pwr_fall)
        begin
            saved_q <= cur_q;
            saved_vld_q <= run_mode && retentive;
        end
        // consumed at power-up; a stop-state loss inits since its fall leaves the copy invalid
        else if (pwr_up)
        begin
            saved_vld_q <= 1'b0;
        end
    end

    // =====================================================
    // control registers written by software
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl_q.mode <= `LCM_RST_MODE;
            ctrl_q.keep <= 1'b0;
            preset_q <= CNT_W'(`LCM_RST_PRESET);
        end
        else if (apb_wr && paddr == `LCM_ADDR_CTRL)
        begin
            ctrl_q.keep <= pwdata[`LCM_KEEP_BIT];
            // unsupported modes are ignored, old mode stays
            if (pwdata[`LCM_MODE_MSB:0] >= `LCM_MODE_2 && pwdata[`LCM_MODE_MSB:0] <= `LCM_MODE_6)
            begin
                ctrl_q.mode <= pwdata[`LCM_MODE_MSB:0];
            end
        end
        else if (apb_wr && paddr == `LCM_ADDR_PRESET)
        begin
            if (pwdata[CNT_W-1:0] > CNT_W'(`LCM_MAX_COUNT))
            begin
                preset_q <= CNT_W'(`LCM_MAX_COUNT);
            end
            else
            begin
                preset_q <= pwdata[CNT_W-1:0];
            end
        end
    end

    // =====================================================
    // apb answer: one wait state, data registered
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            pready_q <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~addr_ok;
            prdata_q <= 32'h00000000;
            if (psel && penable && !pready_q && !pwrite)
            begin
                case (paddr)
                    `LCM_ADDR_CTRL: prdata_q <= {28'h0000000, ctrl_q.keep, ctrl_q.mode};
                    `LCM_ADDR_PRESET: prdata_q <= 32'(preset_q);
                    `LCM_ADDR_CURRENT: prdata_q <= 32'(cur_q);
                    `LCM_ADDR_STATUS: prdata_q <= {29'h00000000, saved_vld_q, run_mode, coil_q};
                    default: prdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign counter_status_coil = coil_q;
    assign count_value = cur_q;
    // =====================================================
    // checks
    property p_clr_zero;
        @(posedge clk) disable iff (!rst_n)
        (rung.clr && !power_lost && !pwr_up && !run_chg) |=> (cur_q == CNT_W'(`LCM_ZERO));
    endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("reset input did not clear");
    property p_down_floor;
        @(posedge clk) disable iff (!rst_n)
        (cur_q == CNT_W'(`LCM_ZERO) && !pwr_up && !run_chg && rung.dir) |=> (cur_q == CNT_W'(`LCM_ZERO));
    endproperty
    a_down_floor: assert property (p_down_floor) else $error("count went below zero");
    property p_mode3_cap;
        @(posedge clk) disable iff (!rst_n)
        (ctrl_q.mode == `LCM_MODE_3 && cur_q >= preset_q && !pwr_up && !run_chg)
            |=> (cur_q <= $past(cur_q));
    endproperty
    a_mode3_cap: assert property (p_mode3_cap) else $error("mode 3 passed preset");
    property p_up_step;
        @(posedge clk) disable iff (!rst_n)
        (pulse_rise && !rung.dir && !rung.clr && !power_lost && !pwr_up && !run_chg
            && ctrl_q.mode != `LCM_MODE_3 && cur_q < CNT_W'(`LCM_MAX_COUNT))
            |=> (cur_q == $past(cur_q) + CNT_W'(`LCM_ONE));
    endproperty
    a_up_step: assert property (p_up_step) else $error("up count step wrong");
    property p_mode5_run;
        @(posedge clk) disable iff (!rst_n)
        (ctrl_q.mode == `LCM_MODE_5 && run_chg && !power_lost && !pwr_up)
            |=> (cur_q == CNT_W'(`LCM_ZERO));
    endproperty
    a_mode5_run: assert property (p_mode5_run) else $error("mode 5 run change not zero");
    property p_keep;
        @(posedge clk) disable iff (!rst_n)
        (retentive && ctrl_q.keep && run_chg && !power_lost && !pwr_up) |=> $stable(cur_q);
    endproperty
    a_keep: assert property (p_keep) else $error("keep flag lost value");
    property p_restore;
        @(posedge clk) disable iff (!rst_n)
        (pwr_up && retentive && saved_vld_q) |=> (cur_q == $past(saved_q));
    endproperty
    a_restore: assert property (p_restore) else $error("value not restored");
    property p_coil_nz;
        @(posedge clk) disable iff (!rst_n)
        (ctrl_q.mode == `LCM_MODE_5 && preset_q == CNT_W'(`LCM_ZERO) && $stable(preset_q)
            && $stable(ctrl_q)) |=> !counter_status_coil;
    endproperty
    a_coil_nz: assert property (p_coil_nz) else $error("coil on with zero preset");
    property p_range;
        @(posedge clk) disable iff (!rst_n)
        (cur_q <= CNT_W'(`LCM_MAX_COUNT)) && (preset_q <= CNT_W'(`LCM_MAX_COUNT));
    endproperty
    a_range: assert property (p_range) else $error("value out of range");
endmodule

// >>> testbench/lcm_rung_model.sv
// ladder rung model: drives pulse, direction and reset input levels
// assumes the counter samples the rung struct on rising clk edges
`timescale 1ns/1ps
module lcm_rung_model (
    input wire logic clk,
    output lcm_pkg::lcm_rung_t rung
);
    import lcm_pkg::*;
    // =====================================================
    // rung levels, quiet at time zero
    initial
    begin
        rung = '0;
    end
    // direction is set first, then k pulses with a random low gap
    // direction and pulses
    task automatic pulses(input int k, input logic d);
        int g;
        @(posedge clk);
        rung.dir <= d;
        for (int i = 0; i < k; i++)
        begin
            @(posedge clk);
            rung.pulse <= 1'b1;
            // a low cycle between rises keeps one count per edge
            @(posedge clk);
            rung.pulse <= 1'b0;
            g = $urandom_range(0, 2);
            repeat (g) @(posedge clk);
        end
    endtask
    task automatic set_clr(input logic v);
        @(posedge clk);
        rung.clr <= v;
    endtask
endmodule

// >>> testbench/ladder_counter_modes_two_to_six_tb.sv
// self-checking bench for the ladder counter, modes 2 to 6
// assumes lcm_counter, lcm_pkg and lcm_rung_model are compiled first
`timescale 1ns/1ps
`include "lcm_defs.svh"
module ladder_counter_modes_two_to_six_tb;
    import lcm_pkg::*;
    // =====================================================
    // stimulus and observed signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    lcm_rung_t rung;
    logic run_mode;
    logic power_lost;
    logic counter_status_coil;
    logic [19:0] count_value;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [31:0] rd, ev, pre; // read data, expected count, preset
    logic [2:0] md; // mode under test
    logic er;
    always #4 clk = ~clk;
    lcm_counter #(.CNT_W(20)) u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rung(rung),
        .run_mode(run_mode), .power_lost(power_lost),
        .counter_status_coil(counter_status_coil), .count_value(count_value));
    lcm_rung_model u_rung (.clk(clk), .rung(rung));
    // =====================================================
    // expectation functions
    function automatic logic [31:0] exp_cnt(input logic [31:0] v, input int k,
        input logic dn);
        logic [31:0] r;
        r = v;
        for (int i = 0; i < k; i++)
            if (dn) r = (r == 32'h0) ? 32'h0 : r - 32'h1;
            else if (!(md == 3'h3 && r >= pre)) r = r + 32'h1;
        return r;
    endfunction
    function automatic logic exp_coil(input logic [31:0] v);
        if (md >= 3'h5) return (pre != 32'h0) && (v >= pre);
        return v >= pre;
    endfunction
    // =====================================================
    // bus and check tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
        num_checks++;
        if (g !== e)
        begin
            $display("MISMATCH %0t %s got %0h exp %0h", $time, s, g, e);
            fails++;
        end
    endtask
    // holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the hang guard ends a wait that never completes
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask
    task automatic step(input int k, input logic dn);
        u_rung.pulses(k, dn);
        ev = exp_cnt(ev, k, dn);
        settle();
    endtask
    task automatic chk_cnt(input string s);
        chk({12'h000, count_value}, ev, s);
        chk({31'h0, counter_status_coil}, {31'h0, exp_coil(ev)}, s);
    endtask
    task automatic run_flip();
        run_mode <= ~run_mode;
        settle();
    endtask
    task automatic pwr_cycle();
        power_lost <= 1'b1;
        settle();
        power_lost <= 1'b0;
        settle();
    endtask
    // new mode and preset, then clear through the reset input
    task automatic setup(input logic kp, input logic [2:0] m, input logic [31:0] p);
        md = m;
        pre = p;
        apb(1'b1, `LCM_ADDR_CTRL, {28'h0, kp, m});
        apb(1'b1, `LCM_ADDR_PRESET, p);
        u_rung.set_clr(1'b1);
        settle();
        u_rung.set_clr(1'b0);
        settle();
        ev = 32'h0;
        chk_cnt("clear");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            wrap_up();
        end
    end
    // =====================================================
    // main sequence
    initial
    begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h00000000;
        run_mode <= 1'b0;
        power_lost <= 1'b0;
        void'($urandom(32'h6A3A));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, `LCM_ADDR_CTRL, 32'h0);
        chk(rd, 32'h2, "ctrl reset");
        apb(1'b1, `LCM_ADDR_CTRL, 32'h7);
        apb(1'b0, `LCM_ADDR_CTRL, 32'h0);
        chk(rd, 32'h2, "bad mode kept");
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        apb(1'b1, `LCM_ADDR_PRESET, 32'hFFFFF);
        apb(1'b0, `LCM_ADDR_PRESET, 32'h0);
        chk(rd, 32'hF423F, "preset clip");
        apb(1'b1, `LCM_ADDR_CURRENT, 32'h7);
        chk({12'h000, count_value}, 32'h0, "current read only");
        run_flip();
        $display("test registers done");
        setup(1'b0, 3'h2, 32'h5);
        step($urandom_range(6, 9), 1'b0);
        chk_cnt("m2 up past preset");
        step(12, 1'b1);
        chk_cnt("m2 down stops");
        run_flip();
        ev = pre;
        chk_cnt("m2 init down");
        u_rung.pulses(0, 1'b0);
        run_flip();
        ev = 32'h0;
        chk_cnt("m2 init up");
        $display("test mode 2 done");
        setup(1'b1, 3'h3, 32'h5);
        step($urandom_range(6, 9), 1'b0);
        chk_cnt("m3 up stops");
        pwr_cycle();
        chk_cnt("m3 power loss");
        run_flip();
        chk_cnt("m3 keep");
        run_flip();
        $display("test mode 3 done");
        setup(1'b1, 3'h4, 32'h3);
        step($urandom_range(4, 8), 1'b0);
        chk_cnt("m4 up past preset");
        pwr_cycle();
        chk_cnt("m4 power loss");
        run_flip();
        chk_cnt("m4 keep");
        run_flip();
        step(12, 1'b1);
        chk_cnt("m4 down halts");
        $display("test mode 4 done");
        setup(1'b0, 3'h5, 32'h3);
        step(4, 1'b0);
        u_rung.pulses(0, 1'b1);
        settle();
        chk_cnt("m5 coil any dir");
        u_rung.set_clr(1'b1);
        u_rung.pulses(2, 1'b0);
        settle();
        ev = 32'h0;
        chk_cnt("m5 reset held");
        u_rung.set_clr(1'b0);
        step(2, 1'b0);
        chk_cnt("m5 below preset");
        pwr_cycle();
        ev = 32'h0;
        chk_cnt("m5 power loss");
        step(5, 1'b0);
        run_flip();
        ev = 32'h0;
        chk_cnt("m5 run stop");
        run_flip();
        apb(1'b1, `LCM_ADDR_PRESET, 32'h0);
        pre = 32'h0;
        step(2, 1'b0);
        chk_cnt("m5 zero preset");
        $display("test mode 5 done");
        setup(1'b1, 3'h6, 32'h4);
        step(5, 1'b0);
        chk_cnt("m6 coil");
        pwr_cycle();
        chk_cnt("m6 power loss");
        apb(1'b0, `LCM_ADDR_STATUS, 32'h0);
        chk(rd, 32'h3, "m6 status");
        run_flip();
        chk_cnt("m6 keep");
        run_flip();
        u_rung.pulses(0, 1'b1);
        u_rung.set_clr(1'b1);
        settle();
        ev = 32'h0;
        chk_cnt("m6 reset");
        u_rung.set_clr(1'b0);
        $display("test mode 6 done");
        wrap_up();
    end
endmodule
